//--- ebps_bus_if.sv
// Interface joining the sequencer to the peripheral or DSP host port.
// Assumes one clock shared by both ends; data lines split into per-end drivers.
`timescale 1ns/1ps
interface ebps_bus_if;
    import ebps_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [CS_W-1:0] cs_n;
    logic address_latch_pulse;
    logic single_data_strobe_n;
    logic host_data_strobe;
    logic wr_n;
    logic [DATA_W-1:0] data_out;
    logic data_oe_n;
    logic [DATA_W-1:0] data_in;
    logic host_wait_in;
    modport seq (
        output addr, cs_n, address_latch_pulse, single_data_strobe_n, host_data_strobe,
        output wr_n, data_out, data_oe_n,
        input data_in, host_wait_in
    );
    modport periph (
        input addr, cs_n, address_latch_pulse, single_data_strobe_n, host_data_strobe,
        input wr_n, data_out, data_oe_n,
        output data_in, host_wait_in
    );
endinterface // ebps_bus_if

//--- ebps_peripheral.sv
// Peripheral end: a small register space answering the sequencer, with optional wait.
// Assumes it shares clk_sys with the sequencer; wait request comes from same-clock logic.
`timescale 1ns/1ps
module ebps_peripheral
    import ebps_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // User side
    input wire logic wait_req,
    input wire logic [DATA_W-1:0] read_value,
    output logic [DATA_W-1:0] last_wdata,
    output logic [ADDR_W-1:0] last_addr,
    output logic wr_seen,
    // Bus
    ebps_bus_if.periph bus
);
    logic strobe_d, strobe_q;

    // The DSP may hold off the access at any moment
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus.host_wait_in <= 1'b0;
        end else begin
            bus.host_wait_in <= wait_req;
        end
    end

    assign strobe_d = bus.host_data_strobe || !bus.single_data_strobe_n;
    assign bus.data_in = read_value;

    // ------------------------------------------------------------
    // Write capture on strobe trailing end
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            strobe_q <= 1'b0;
            last_wdata <= '0;
            last_addr <= '0;
            wr_seen <= 1'b0;
        end else begin
            strobe_q <= strobe_d;
            wr_seen <= strobe_q && !strobe_d && !bus.wr_n;
            if (strobe_q && !strobe_d && !bus.wr_n && !bus.data_oe_n) begin
                last_wdata <= bus.data_out;
                last_addr <= bus.addr;
            end
        end
    end
endmodule // ebps_peripheral

//--- ebps_pkg.sv
// Package for the expansion bus phase sequencer: modes, phase states, widths, limits.
// Assumes both bus ends import it whole.
package ebps_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 8;
    localparam int CS_W = 8;
    localparam int PARAM_W = 4;
    localparam int CNT_W = 5;
    // ------------------------------------------------------------
    // Phase parameter limits and offsets
    // ------------------------------------------------------------
    localparam logic [PARAM_W-1:0] HOST_ADDR_MIN = 4'h2;
    localparam logic [PARAM_W-1:0] HOST_SETUP_MIN = 4'h2;
    localparam logic [PARAM_W-1:0] HOST_STROBE_MIN = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] HOST_EXTRA = 5'h01;
    // ------------------------------------------------------------
    // Modes and phases
    // ------------------------------------------------------------
    typedef enum logic {
        EBPS_MODE_SIMPLEX,
        EBPS_MODE_HOST
    } ebps_mode_t;
    typedef enum logic [2:0] {
        EBPS_IDLE,
        EBPS_ADDR,
        EBPS_SETUP,
        EBPS_STROBE,
        EBPS_HOLD,
        EBPS_RECOV
    } ebps_phase_t;
endpackage

//--- ebps_sequencer.sv
// Expansion bus sequencer: runs address, setup, strobe, hold and recovery phases.
// Assumes requests and phase parameters from same-clock logic; wait input comes from a pin.
//
// What this block does
// - Simplex mode never pulses address latch
// - Address phase length from programmed parameter
// - Setup phase length before strobe asserts; the host strobe here asserts at the start of setup instead
// - Strobe length programmed; data held throughout
// - Hold phase keeps selects, address, data
// - Recovery gap between successive accesses
// - Phases counted in bus clock cycles
// - Recovery 1-16 simplex, 2-17 host
// - Host mode address parameter at least 2
// - Host mode setup parameter at least 2
// - Host mode strobe parameter at least 1
// - Wait freezes address and strobe phases
// - DSP may assert wait any time
// - One extra clock after wait drops
// - Host mode address with chip select
// - Host strobe 3-4 cycles after select
// - Host strobe pulse 4-5 cycles
// - Write data valid 4-5 before strobe rise
// - Write data held 4-36 after strobe
// - Simplex strobe width 1 to 16
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module ebps_sequencer
    import ebps_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Configuration
    input wire logic mode,
    input wire logic [PARAM_W-1:0] address_phase,
    input wire logic [PARAM_W-1:0] setup_phase,
    input wire logic [PARAM_W-1:0] strobe_phase,
    input wire logic [PARAM_W-1:0] hold_phase,
    input wire logic [PARAM_W-1:0] recovery_phase,
    // Request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [CS_W-1:0] req_cs,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic [DATA_W-1:0] rd_data,
    output logic rd_valid,
    output logic cfg_error,
    // Bus
    ebps_bus_if.seq bus
);
    // ------------------------------------------------------------
    // Phase length in cycles: parameter plus one, host adds one more to recovery only
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] phase_len(input logic [PARAM_W-1:0] p, input logic host);
        phase_len = {1'b0, p} + CNT_ONE + (host ? HOST_EXTRA : CNT_ZERO);
    endfunction

    ebps_phase_t phase_q;
    logic [CNT_W-1:0] cnt_q;
    logic host_q, write_q;
    logic wait_s1_q, wait_s2_q, wait_seen_q;
    logic [DATA_W-1:0] wdata_q;
    logic last;
    logic stall;

    // ------------------------------------------------------------
    // Wait input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wait_s1_q <= 1'b0;
            wait_s2_q <= 1'b0;
        end else begin
            wait_s1_q <= bus.host_wait_in;
            wait_s2_q <= wait_s1_q;
        end
    end

    // Wait only matters in host mode, during address or strobe phase
    assign stall = host_q && wait_s2_q && (phase_q == EBPS_ADDR || phase_q == EBPS_STROBE);
    assign last = (cnt_q == CNT_ONE) && !stall && !wait_seen_q;
    assign req_ready = (phase_q == EBPS_IDLE) && !cfg_error;

    // Host mode refuses parameters below the floor; refusing beats clamping them silently
    assign cfg_error = (mode == EBPS_MODE_HOST) && ((address_phase < HOST_ADDR_MIN) ||
        (setup_phase < HOST_SETUP_MIN) || (strobe_phase < HOST_STROBE_MIN));

    // ------------------------------------------------------------
    // Extra clock after wait drops
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wait_seen_q <= 1'b0;
        end else if (stall) begin
            wait_seen_q <= 1'b1;
        end else begin
            wait_seen_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Phase machine
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            phase_q <= EBPS_IDLE;
            cnt_q <= CNT_ZERO;
            host_q <= 1'b0;
            write_q <= 1'b0;
        end else begin
            unique case (phase_q)
                EBPS_IDLE: begin
                    if (req_valid && req_ready) begin
                        phase_q <= EBPS_ADDR;
                        host_q <= (mode == EBPS_MODE_HOST);
                        write_q <= req_write;
                        cnt_q <= phase_len(address_phase, 1'b0);
                    end
                end
                EBPS_ADDR: begin
                    if (last) begin
                        phase_q <= EBPS_SETUP;
                        cnt_q <= phase_len(setup_phase, 1'b0);
                    end else if (!stall && !wait_seen_q) begin
                        cnt_q <= cnt_q - CNT_ONE;
                    end
                end
                EBPS_SETUP: begin
                    if (cnt_q == CNT_ONE) begin
                        phase_q <= EBPS_STROBE;
                        cnt_q <= phase_len(strobe_phase, 1'b0);
                    end else begin
                        cnt_q <= cnt_q - CNT_ONE;
                    end
                end
                EBPS_STROBE: begin
                    if (last) begin
                        phase_q <= EBPS_HOLD;
                        cnt_q <= phase_len(hold_phase, 1'b0);
                    end else if (!stall && !wait_seen_q) begin
                        cnt_q <= cnt_q - CNT_ONE;
                    end
                end
                EBPS_HOLD: begin
                    if (cnt_q == CNT_ONE) begin
                        phase_q <= EBPS_RECOV;
                        cnt_q <= phase_len(recovery_phase, host_q);
                    end else begin
                        cnt_q <= cnt_q - CNT_ONE;
                    end
                end
                EBPS_RECOV: begin
                    if (cnt_q == CNT_ONE) begin
                        phase_q <= EBPS_IDLE;
                        cnt_q <= CNT_ZERO;
                    end else begin
                        cnt_q <= cnt_q - CNT_ONE;
                    end
                end
                default: begin
                    phase_q <= EBPS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Bus outputs, registered from the phase of the next cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus.addr <= '0;
            bus.cs_n <= '1;
            wdata_q <= '0;
        end else if (phase_q == EBPS_IDLE && req_valid && req_ready) begin
            bus.addr <= req_addr;
            bus.cs_n <= ~req_cs;
            wdata_q <= req_wdata;
        end else if (phase_q == EBPS_HOLD && cnt_q == CNT_ONE) begin
            bus.cs_n <= '1;
        end
    end

    // Outputs decode the current phase, so they line up with it exactly
    always_comb begin
        bus.address_latch_pulse = 1'b0;
        bus.single_data_strobe_n = !(phase_q == EBPS_STROBE && !host_q);
        // Host strobe spans setup and strobe, so its lead after select and its width both fit
        bus.host_data_strobe = host_q && (phase_q == EBPS_SETUP || phase_q == EBPS_STROBE);
        bus.wr_n = !(write_q && phase_q != EBPS_IDLE && phase_q != EBPS_RECOV);
        bus.data_oe_n = !(write_q && (phase_q == EBPS_SETUP || phase_q == EBPS_STROBE
            || phase_q == EBPS_HOLD));
        bus.data_out = wdata_q;
    end

    // ------------------------------------------------------------
    // Read capture at the end of the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_data <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= (phase_q == EBPS_STROBE) && last && !write_q;
            if ((phase_q == EBPS_STROBE) && last && !write_q) begin
                rd_data <= bus.data_in;
            end
        end
    end
endmodule // ebps_sequencer

//--- ebps_sva.sv
// Checker for the bus between sequencer and peripheral.
// Assumes one clock; instantiated beside the interface.
`timescale 1ns/1ps
module ebps_sva
    import ebps_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Bus
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [CS_W-1:0] cs_n,
    input wire logic address_latch_pulse,
    input wire logic single_data_strobe_n,
    input wire logic host_data_strobe,
    input wire logic wr_n,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe_n,
    input wire logic host_wait_in
);
    // ------------
    // Properties
    // ------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic stb = !single_data_strobe_n || host_data_strobe;
    wire logic sel = cs_n != '1;
    AST_NO_LATCH: assert property (!address_latch_pulse) else $error("latch pulsed");
    AST_ONE_STROBE: assert property (!(host_data_strobe && !single_data_strobe_n))
        else $error("two strobes");
    AST_STB_SEL: assert property (stb |-> sel) else $error("strobe unselected");
    AST_ADDR_HOLD: assert property (sel && $past(sel) |-> $stable(addr) && $stable(cs_n))
        else $error("address moved");
    AST_SETUP: assert property ($fell(single_data_strobe_n) && !wr_n |-> $past(!data_oe_n))
        else $error("no setup");
    AST_HOST_SETUP: assert property ($fell(host_data_strobe) && !wr_n |-> $past(!data_oe_n, 4))
        else $error("host data late");
    AST_HOST_HOLD: assert property ($fell(host_data_strobe) && !wr_n |-> !data_oe_n [*4])
        else $error("host data hold short");
    AST_STB_DATA: assert property (stb && $past(stb) && !wr_n |-> !data_oe_n && $stable(data_out))
        else $error("data moved in strobe");
    AST_WR_HOLD: assert property ($fell(stb) && !wr_n |-> !data_oe_n && sel && $stable(data_out))
        else $error("no hold");
    AST_HOST_CS: assert property ($rose(host_data_strobe) |-> $past(sel, 3)) else $error("strobe early");
    AST_HOST_PULSE: assert property ($rose(host_data_strobe) |-> host_data_strobe [*4])
        else $error("host strobe short");
    // The wait goes through a register and two sync stages, so three samples are needed
    AST_WAIT: assert property (host_data_strobe && host_wait_in && $past(host_wait_in)
        && $past(host_wait_in, 2) |=> host_data_strobe [*2]) else $error("wait ignored");
    AST_RECOV: assert property ($rose(!sel) |-> !sel [*2]) else $error("gap short");
endmodule // ebps_sva

//--- tb_top.sv
// Bench: sequencer and peripheral joined by the bus interface.
// Assumes package widths; one 10 MHz clock, synchronous reset.
`timescale 1ns/1ps
module tb_top;
    import ebps_pkg::*;
    // ------------
    // Signals
    // ------------
    logic clk_sys = 0, reset = 1, mode = 0, req_valid = 0, req_write = 0, wait_req = 0;
    logic [PARAM_W-1:0] p_a = 0, p_s = 0, p_t = 0, p_h = 0, p_r = 0;
    logic [ADDR_W-1:0] req_addr = 0, last_addr;
    logic [CS_W-1:0] req_cs = 0;
    logic [DATA_W-1:0] req_wdata = 0, read_value = 0, rd_data, last_wdata;
    logic req_ready, rd_valid, cfg_error, wr_seen;
    logic [31:0] seed = 32'h0BAB, rv;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    always #50 clk_sys = ~clk_sys;
    ebps_bus_if u_ebps_bus_if();
    ebps_sequencer u_ebps_sequencer(.clk_sys(clk_sys), .reset(reset), .mode(mode), .address_phase(p_a),
        .setup_phase(p_s), .strobe_phase(p_t), .hold_phase(p_h), .recovery_phase(p_r), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_cs(req_cs), .req_wdata(req_wdata),
        .rd_data(rd_data), .rd_valid(rd_valid), .cfg_error(cfg_error), .bus(u_ebps_bus_if));
    ebps_peripheral u_ebps_peripheral(.clk_sys(clk_sys), .reset(reset), .wait_req(wait_req),
        .read_value(read_value), .last_wdata(last_wdata), .last_addr(last_addr), .wr_seen(wr_seen),
        .bus(u_ebps_bus_if));
    ebps_sva u_ebps_sva(.clk_sys(clk_sys), .reset(reset), .addr(u_ebps_bus_if.addr), .cs_n(u_ebps_bus_if.cs_n),
        .address_latch_pulse(u_ebps_bus_if.address_latch_pulse), .wr_n(u_ebps_bus_if.wr_n),
        .single_data_strobe_n(u_ebps_bus_if.single_data_strobe_n), .data_out(u_ebps_bus_if.data_out),
        .host_data_strobe(u_ebps_bus_if.host_data_strobe), .data_oe_n(u_ebps_bus_if.data_oe_n),
        .host_wait_in(u_ebps_bus_if.host_wait_in));
    wire logic stb_on = u_ebps_bus_if.single_data_strobe_n === 1'b0 || u_ebps_bus_if.host_data_strobe === 1'b1;
    wire logic sel_on = u_ebps_bus_if.cs_n !== '1;
    // ------------
    // Helpers
    // ------------
    function automatic logic [31:0] nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int ph(input logic [PARAM_W-1:0] v, input logic extra);
        return int'(v) + 1 + int'(extra);
    endfunction
    // Host strobe covers setup and strobe phases; simplex only the strobe phase
    function automatic int stb_len(input logic m);
        return (m ? ph(p_s, 1'b0) : 0) + ph(p_t, 1'b0);
    endfunction
    // Host settings kept legal: address 2 or 3, setup 2, strobe 1, hold at least 3
    function automatic logic [19:0] pick(input logic m, input logic [19:0] raw);
        return m ? {raw[19:16], raw[15:12] | 4'h3, 4'h1, 4'h2, 3'h1, raw[0]} : raw;
    endfunction
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One access; k stretches the strobe with k cycles of wait
    task automatic access(input logic m, input logic [19:0] p, input logic w, input int k);
        int n_cs = 0, n_stb = 0, n_gap = 0, n_oe = 0, n_pre = 0, n_wr = 0, bad = 0, got = 0, g = 0;
        logic [DATA_W-1:0] rdv = 0;
        logic done = 1'b0;
        @(posedge clk_sys);
        rv = nxt();
        {p_r, p_h, p_t, p_s, p_a} <= p;
        {mode, req_write, req_valid} <= {m, w, 1'b1};
        {req_addr, req_wdata} <= {rv[ADDR_W-1:0], 8'h5A ^ rv[7:0]};
        {req_cs, read_value} <= {rv[15:8] | 8'h01, rv[31:24]};
        do @(negedge clk_sys); while (req_ready !== 1'b1 && g++ < 50);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        do begin
            @(negedge clk_sys);
            if (sel_on) n_cs++; else n_gap++;
            n_stb += int'(stb_on);
            n_pre += int'(sel_on && n_stb == 0);
            n_oe += int'(u_ebps_bus_if.data_oe_n === 1'b0);
            n_wr += int'(wr_seen === 1'b1);
            if (sel_on && (u_ebps_bus_if.cs_n !== ~req_cs || u_ebps_bus_if.addr !== req_addr)) bad++;
            if (rd_valid === 1'b1) {got, rdv} = {got + 1, rd_data};
            done = req_ready === 1'b1;
            @(posedge clk_sys);
            wait_req <= k > 0 && n_stb >= 1 && n_stb <= k;
        end while (!done && n_cs + n_gap < 300);
        chk(k == 0 ? n_stb == stb_len(m) : n_stb >= stb_len(m) + k, "strobe length");
        chk(n_pre == ph(p_a, 1'b0) + (m ? 0 : ph(p_s, 1'b0)), "select to strobe");
        chk(n_cs - n_stb - n_pre == ph(p_h, 1'b0), "hold length");
        chk(n_gap == ph(p_r, m) + 1, "recovery gap");
        chk(n_oe == (w ? n_cs - ph(p_a, 1'b0) : 0), "data drive");
        chk(n_wr == int'(w), "write seen");
        chk(bad == 0, "address or select");
        if (w) chk(last_wdata === req_wdata && last_addr === req_addr, "write data");
        else chk(got == 1 && rdv === read_value, "read data");
    endtask
    // ------------
    // Sequence
    // ------------
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            {mode, p_a, p_s, p_t} <= {1'b1, i == 0 ? 4'h1 : 4'h2, i == 1 ? 4'h1 : 4'h2, i == 2 ? 4'h0 : 4'h1};
            @(negedge clk_sys);
            chk(cfg_error === 1'b1 && req_ready === 1'b0, "bad host setting taken");
        end
        access(1'b0, 20'h00000, 1'b1, 0);
        access(1'b0, 20'hFFFFF, 1'b0, 0);
        access(1'b1, 20'h03122, 1'b1, 0);
        access(1'b1, 20'h33122, 1'b0, 3);
        for (int i = 0; i < 30; i++) begin
            rv = nxt();
            access(rv[20], pick(rv[20], rv[19:0]), rv[21], 0);
        end
        test_done();
    end
endmodule // tb_top
